// *** design/event_latch.sv ***
// One latched event byte with enable mask and summary bit
`include "status_params.svh"
module event_latch (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire status_pkg::event_byte_t setBits,
    input  wire logic               readClr,
    input  wire logic               clrStatus,
    input  wire status_pkg::event_byte_t enableMask,
    output status_pkg::event_byte_t flags,
    output logic                    summary
);
    import status_pkg::*;
    event_byte_t flags_r;

    // Set wins over read-clear so no event is lost
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= `EVT_RESET;
        end else if (readClr || clrStatus) begin
            flags_r <= setBits; // RULE23
        end else begin
            flags_r <= flags_r | setBits; // RULE23
        end
    end

    assign flags   = flags_r;
    assign summary = |(flags_r & enableMask); // RULE24

    a_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !$past(readClr || clrStatus) |-> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("event bit dropped without clear"); // RULE23
endmodule // event_latch

// *** design/fault_push_if.sv ***
// Push channel into the fault code queue
interface fault_push_if;
    import status_pkg::*;
    logic        push;
    fault_code_t code;
    modport src (output push, output code);
    modport dst (input push, input code);
endinterface

// *** design/fault_queue.sv ***
// Oldest-first fault code queue with overflow marker
`include "status_params.svh"
module fault_queue #(
    parameter int DEPTH = `FAULT_DEPTH
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    fault_push_if.dst                    pushIn,
    input  wire logic                    pop,
    input  wire logic                    flush,
    output status_pkg::fault_code_t      popCode,
    output logic                         popValid,
    output logic [$clog2(DEPTH+1)-1:0]   count,
    output logic                         overflowed
);
    import status_pkg::*;
    localparam int AW = $clog2(DEPTH);
    fault_code_t            mem [DEPTH];
    logic [AW-1:0]          rdPtr_r;
    logic [AW-1:0]          wrPtr_r;
    logic [$clog2(DEPTH+1)-1:0] count_r;
    logic                   ovf_r;
    fault_code_t            popCode_r;
    logic                   popValid_r;
    logic                   doPop;
    logic                   doPush;
    fault_code_t            wrCode;
    logic                   full;

    assign full  = (count_r == DEPTH[$clog2(DEPTH+1)-1:0]);
    assign doPop = pop && (count_r != '0);
    // Last slot takes the overflow marker, later codes drop while marked
    assign doPush = pushIn.push && !ovf_r && (!full || doPop); // RULE13
    assign wrCode = (count_r == DEPTH[$clog2(DEPTH+1)-1:0] - 1'b1 && !doPop)
                    ? `CODE_OVERFLOW : pushIn.code; // RULE13

    function automatic logic [AW-1:0] incr(input logic [AW-1:0] p);
        incr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            mem[wrPtr_r] <= wrCode; // RULE10
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdPtr_r <= '0;
            wrPtr_r <= '0;
            count_r <= '0;
            ovf_r   <= 1'b0;
        end else if (flush) begin
            rdPtr_r <= '0;
            wrPtr_r <= '0;
            count_r <= '0;
            ovf_r   <= 1'b0;
        end else begin
            if (doPush) begin
                wrPtr_r <= incr(wrPtr_r);
            end
            if (doPop) begin
                rdPtr_r <= incr(rdPtr_r); // RULE25
            end
            count_r <= count_r + (doPush ? 1'b1 : 1'b0) - (doPop ? 1'b1 : 1'b0);
            if (doPush && wrCode == `CODE_OVERFLOW && pushIn.code != `CODE_OVERFLOW) begin
                ovf_r <= 1'b1;
            end else if (doPop) begin
                ovf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            popCode_r  <= `CODE_NONE;
            popValid_r <= 1'b0;
        end else begin
            popValid_r <= pop;
            if (pop) begin
                popCode_r <= doPop ? mem[rdPtr_r] : `CODE_NONE; // RULE11
            end
        end
    end

    assign popCode    = popCode_r;
    assign popValid   = popValid_r;
    assign count      = count_r;
    assign overflowed = ovf_r;

    a_queue_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_r <= DEPTH) else $error("queue count beyond depth"); // RULE10
    a_empty_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pop && count_r == '0 && !flush |=> popValid && popCode == `CODE_NONE)
        else $error("empty pop not zero"); // RULE11
    a_pop_shrinks: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pop && count_r != '0 && !pushIn.push && !flush |=> count_r == $past(count_r) - 1'b1)
        else $error("pop did not remove code"); // RULE11
    a_full_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
        full && !pop && !flush |=> count_r == $past(count_r))
        else $error("full queue grew"); // RULE13
endmodule // fault_queue

// *** design/status_event_error_queue.sv ***
// Status registers, summary bits, fault queue and fault lamp
`include "status_params.svh"
module status_event_error_queue #(
    parameter int DEPTH = `FAULT_DEPTH
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    // Standard event sources, one-cycle pulses from same-clock logic
    input  wire logic                         opsComplete,
    input  wire logic                         powerOnEvent,
    // Instrument event sources, pulses from same-clock logic
    input  wire logic                         input_event_seen,
    input  wire logic                         cycleBusy,
    input  wire logic                         cycle_done,
    input  wire logic                         train_done,
    input  wire logic                         cycleInhibited,
    input  wire logic                         cycleAborted,
    // Lock detector levels from outside
    input  wire logic                         pllLocked,
    input  wire logic                         atomicRefLocked,
    // Remote command failure report
    input  wire logic                         remoteFault,
    input  wire status_pkg::remote_fault_t    remoteFaultKind,
    // Self-test and calibration failures
    input  wire logic                         selfTestFault,
    input  wire status_pkg::selftest_fault_t  selfTestKind,
    input  wire logic [3:0]                   selfTestIndex,
    input  wire logic                         calFault,
    input  wire logic [3:0]                   calIndex,
    // Host command port
    input  wire logic                         readStdFlags,
    input  wire logic                         readInstFlags,
    input  wire logic                         clearStatus,
    input  wire logic                         writeStdMask,
    input  wire logic                         writeInstMask,
    input  wire status_pkg::event_byte_t      maskData,
    input  wire logic                         pop_fault_code,
    output status_pkg::event_byte_t           readData,
    output logic                              readValid,
    output status_pkg::fault_code_t           faultCode,
    output logic                              faultCodeValid,
    output logic                              standardSummaryFlag,
    output logic                              instrument_summary_flag,
    output status_pkg::event_byte_t           standardEventMask,
    output status_pkg::event_byte_t           instrument_event_mask,
    output logic                              faultLamp,
    output logic [$clog2(DEPTH+1)-1:0]        faultCount,
    output logic                              dropOutput,
    output logic                              flushBuffers
);
    import status_pkg::*;

    fault_push_if pushBus ();

    logic         pllMeta_r;
    logic         pllSync_r;
    logic         pllPrev_r;
    logic         refMeta_r;
    logic         refSync_r;
    logic         refPrev_r;
    event_byte_t  stdSet;
    event_byte_t  instSet;
    event_byte_t  stdFlags;
    event_byte_t  instFlags;
    event_byte_t  stdMask_r;
    event_byte_t  instMask_r;
    event_byte_t  readData_r;
    logic         readValid_r;
    logic         stdSummary;
    logic         instSummary;
    fault_code_t  remoteCode;
    fault_code_t  devCode;
    logic         isQueryErr;
    logic         isExecErr;
    logic         isCmdErr;
    logic         lamp_r;
    logic         dropOut_r;
    logic         flush_r;
    logic         popValid;
    logic [$clog2(DEPTH+1)-1:0] count;

    // Lock levels are asynchronous; two flops before the edge detector
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pllMeta_r <= 1'b1;
            pllSync_r <= 1'b1;
            pllPrev_r <= 1'b1;
            refMeta_r <= 1'b1;
            refSync_r <= 1'b1;
            refPrev_r <= 1'b1;
        end else begin
            pllMeta_r <= pllLocked;
            pllSync_r <= pllMeta_r;
            pllPrev_r <= pllSync_r;
            refMeta_r <= atomicRefLocked;
            refSync_r <= refMeta_r;
            refPrev_r <= refSync_r;
        end
    end

    // Remote fault kind to queued code
    always_comb begin
        unique case (remoteFaultKind)
            FLT_NONE:       remoteCode = `CODE_NONE;
            FLT_ILL_VALUE:  remoteCode = `CODE_ILL_VALUE; // RULE14
            FLT_ILL_MODE:   remoteCode = `CODE_ILL_MODE; // RULE14
            FLT_LOCKED:     remoteCode = `CODE_LOCKED; // RULE14
            FLT_LOST_DATA:  remoteCode = `CODE_LOST_DATA; // RULE15
            FLT_NO_LISTEN:  remoteCode = `CODE_NO_LISTEN; // RULE16
            FLT_BAD_NAME:   remoteCode = `CODE_BAD_NAME; // RULE19
            FLT_UNKNOWN:    remoteCode = `CODE_UNKNOWN; // RULE19
            FLT_ILL_QUERY:  remoteCode = `CODE_ILL_QUERY; // RULE20
            FLT_ILL_SET:    remoteCode = `CODE_ILL_SET; // RULE20
            FLT_MISS_PARAM: remoteCode = `CODE_MISS_PARAM; // RULE20
            FLT_BAD_FLOAT:  remoteCode = `CODE_BAD_FLOAT; // RULE21
            FLT_INT_OVFL:   remoteCode = `CODE_INT_OVFL; // RULE21
            FLT_BAD_HEX:    remoteCode = `CODE_BAD_HEX; // RULE21
            FLT_FRAMING:    remoteCode = `CODE_FRAMING; // RULE22
            FLT_OVERRUN:    remoteCode = `CODE_OVERRUN; // RULE22
        endcase
    end

    // Self-test and calibration codes; calibration code saturates at 91
    always_comb begin
        devCode = `CODE_NONE;
        if (calFault) begin
            devCode = (calIndex > 4'd11) ? `CODE_CAL_LAST : (`CODE_CAL_BASE + {4'h0, calIndex}); // RULE18
        end else begin
            unique case (selfTestKind)
                ST_NONE: devCode = `CODE_NONE;
                ST_ROM:  devCode = `CODE_ROM_CHECK; // RULE17
                ST_LINK: devCode = `CODE_LINK_BASE + {4'h0, selfTestIndex}; // RULE17
                ST_CHAN: devCode = `CODE_CHAN_BASE + {4'h0, (selfTestIndex > 4'd9) ? 4'd9 : selfTestIndex}; // RULE17
            endcase
        end
    end

    // Remote faults take priority; a simultaneous self-test fault is dropped
    assign pushBus.push = (remoteFault && remoteFaultKind != FLT_NONE) ||
                          ((selfTestFault || calFault) && devCode != `CODE_NONE); // RULE10
    assign pushBus.code = (remoteFault && remoteFaultKind != FLT_NONE) ? remoteCode : devCode;

    assign isQueryErr = remoteFault && (remoteFaultKind == FLT_LOST_DATA || remoteFaultKind == FLT_NO_LISTEN);
    assign isExecErr  = remoteFault && (remoteFaultKind == FLT_ILL_VALUE || remoteFaultKind == FLT_ILL_MODE ||
                                        remoteFaultKind == FLT_LOCKED);
    assign isCmdErr   = remoteFault && !isQueryErr && !isExecErr && remoteFaultKind != FLT_NONE &&
                        remoteFaultKind != FLT_FRAMING && remoteFaultKind != FLT_OVERRUN;

    always_comb begin
        stdSet = 8'h00;
        stdSet[`STD_OPC_BIT]    = opsComplete; // RULE1
        stdSet[`STD_QUERY_BIT]  = isQueryErr; // RULE2
        stdSet[`STD_DEVDEP_BIT] = selfTestFault || calFault; // RULE2
        stdSet[`STD_EXEC_BIT]   = isExecErr; // RULE2
        stdSet[`STD_CMD_BIT]    = isCmdErr; // RULE3
        stdSet[`STD_PON_BIT]    = powerOnEvent; // RULE3
    end

    always_comb begin
        instSet = {!refSync_r && refPrev_r, // RULE8
                   !pllSync_r && pllPrev_r, // RULE8
                   cycleAborted, // RULE7
                   cycleInhibited, // RULE7
                   train_done, // RULE6
                   cycle_done, // RULE6
                   input_event_seen && cycleBusy, // RULE5
                   input_event_seen}; // RULE5
    end

    event_latch u_std (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .setBits    (stdSet),
        .readClr    (readStdFlags),
        .clrStatus  (clearStatus),
        .enableMask (stdMask_r),
        .flags      (stdFlags),
        .summary    (stdSummary)
    );

    event_latch u_inst (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .setBits    (instSet),
        .readClr    (readInstFlags),
        .clrStatus  (clearStatus),
        .enableMask (instMask_r),
        .flags      (instFlags),
        .summary    (instSummary)
    );

    // Masks survive clear-status; only explicit writes change them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stdMask_r  <= `MASK_RESET;
            instMask_r <= `MASK_RESET;
        end else begin
            if (writeStdMask) begin
                stdMask_r <= maskData & `STD_USED_MASK; // RULE4
            end
            if (writeInstMask) begin
                instMask_r <= maskData; // RULE9
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readData_r  <= 8'h00;
            readValid_r <= 1'b0;
        end else begin
            readValid_r <= readStdFlags || readInstFlags;
            if (readStdFlags) begin
                readData_r <= stdFlags;
            end else if (readInstFlags) begin
                readData_r <= instFlags;
            end
        end
    end

    fault_queue #(.DEPTH(DEPTH)) u_queue (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .pushIn     (pushBus),
        .pop        (pop_fault_code),
        .flush      (clearStatus),
        .popCode    (faultCode),
        .popValid   (popValid),
        .count      (count),
        .overflowed ()
    );

    // Lamp on with any queued fault, off once the queue drains
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lamp_r <= 1'b0;
        end else if (remoteFault) begin
            lamp_r <= 1'b1; // RULE12
        end else begin
            lamp_r <= (count != '0) || pushBus.push; // RULE12
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dropOut_r <= 1'b0;
            flush_r   <= 1'b0;
        end else begin
            dropOut_r <= remoteFault && (remoteFaultKind == FLT_NO_LISTEN ||
                                         remoteFaultKind == FLT_LOST_DATA); // RULE16
            flush_r   <= remoteFault && remoteFaultKind == FLT_OVERRUN; // RULE22
        end
    end

    assign readData                = readData_r;
    assign readValid               = readValid_r;
    assign faultCodeValid          = popValid;
    assign standardSummaryFlag     = stdSummary;
    assign instrument_summary_flag = instSummary;
    assign standardEventMask       = stdMask_r;
    assign instrument_event_mask   = instMask_r;
    assign faultLamp               = lamp_r;
    assign faultCount              = count;
    assign dropOutput              = dropOut_r;
    assign flushBuffers            = flush_r;

    a_opc_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        opsComplete |=> stdFlags[`STD_OPC_BIT]) else $error("complete bit not set"); // RULE1
    a_exec_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        remoteFault && remoteFaultKind == FLT_ILL_VALUE |=> stdFlags[`STD_EXEC_BIT])
        else $error("execution bit not set"); // RULE2
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stdFlags[1] == 1'b0 && stdFlags[6] == 1'b0) else $error("reserved bit set"); // RULE3
    a_std_summary: assert property (@(posedge clk_sys) disable iff (!reset_n)
        standardSummaryFlag == |(stdFlags & stdMask_r)) else $error("standard summary wrong"); // RULE4
    a_rate_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
        input_event_seen && cycleBusy |=> instFlags[1] && instFlags[0]) else $error("rate bit missing"); // RULE5
    a_pll_loss: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(pllLocked) |-> ##[3:4] instFlags[6]) else $error("pll unlock not flagged"); // RULE8
    a_inst_summary: assert property (@(posedge clk_sys) disable iff (!reset_n)
        instMask_r == 8'h00 |-> !instrument_summary_flag) else $error("masked summary set"); // RULE9
    a_lamp_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
        remoteFault |=> faultLamp) else $error("lamp not lit"); // RULE12
    a_overrun_flush: assert property (@(posedge clk_sys) disable iff (!reset_n)
        remoteFault && remoteFaultKind == FLT_OVERRUN |=> flushBuffers) else $error("no flush"); // RULE22
    c_pop_code: cover property (@(posedge clk_sys) faultCodeValid && faultCode != `CODE_NONE);
    c_overflow: cover property (@(posedge clk_sys) faultCodeValid && faultCode == `CODE_OVERFLOW);
    c_lamp_off: cover property (@(posedge clk_sys) $fell(faultLamp));
    c_summary: cover property (@(posedge clk_sys) instrument_summary_flag && standardSummaryFlag);
endmodule // status_event_error_queue

// *** design/status_params.svh ***
// Offsets-free constants for the status, event and fault-code block
// Summary of operation
// (RULE1) Set standard bit 0 when all earlier commands have completed.
// (RULE2) Standard bits 2,3,4: query, device-dependent, execution error.
// (RULE3) Standard bit 5 syntax error, bit 7 power cycle; 1 and 6 reserved.
// (RULE4) Standard enable mask selects bits reaching the standard summary bit.
// (RULE5) Instrument bit 0 on trigger; bit 1 on trigger during running cycle.
// (RULE6) Instrument bit 2 on cycle done, bit 3 on train done.
// (RULE7) Instrument bit 4 on inhibited cycle, bit 5 on aborted cycle.
// (RULE8) Instrument bit 6 on PLL unlock, bit 7 on atomic reference unlock.
// (RULE9) Instrument enable mask selects bits reaching the instrument summary bit.
// (RULE10) Fault queue holds up to 20 codes from self test, parsing, execution.
// (RULE11) One code removed per pop request; empty queue returns code 0.
// (RULE12) Fault lamp lights on any failure, goes off when queue read empty.
// (RULE13) Full queue records 254 and drops later codes until space frees.
// (RULE14) Execution codes: 10 range, 11 mode, 15 locked by another interface.
// (RULE15) Code 30 when response data is lost.
// (RULE16) Code 32 when talking with no listener; pending output dropped.
// (RULE17) Self-test codes: 40 checksum, 51 up links, 62 to 71 channel delays.
// (RULE18) Calibration failure codes 80 to 91.
// (RULE19) Code 110 malformed command name, 111 unknown command.
// (RULE20) Codes 112 illegal query, 113 illegal set, 116 missing parameters.
// (RULE21) Codes 118 bad float, 121 integer overflow, 122 bad hexadecimal.
// (RULE22) Code 170 framing or parity; 171 overrun and flush both buffers.
// (RULE23) Event bits latch; cleared only by reading or clear-status.
// (RULE24) Summary bit set while any event bit and its enable are both set.
// (RULE25) Codes returned oldest first.
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH
`define STD_OPC_BIT      0
`define STD_QUERY_BIT    2
`define STD_DEVDEP_BIT   3
`define STD_EXEC_BIT     4
`define STD_CMD_BIT      5
`define STD_PON_BIT      7
`define STD_USED_MASK    8'hbd
`define FAULT_DEPTH      20
`define CODE_NONE        8'h00
`define CODE_OVERFLOW    8'hfe
`define CODE_ILL_VALUE   8'h0a
`define CODE_ILL_MODE    8'h0b
`define CODE_LOCKED      8'h0f
`define CODE_LOST_DATA   8'h1e
`define CODE_NO_LISTEN   8'h20
`define CODE_ROM_CHECK   8'h28
`define CODE_LINK_BASE   8'h33
`define CODE_CHAN_BASE   8'h3e
`define CODE_CAL_BASE    8'h50
`define CODE_CAL_LAST    8'h5b
`define CODE_BAD_NAME    8'h6e
`define CODE_UNKNOWN     8'h6f
`define CODE_ILL_QUERY   8'h70
`define CODE_ILL_SET     8'h71
`define CODE_MISS_PARAM  8'h74
`define CODE_BAD_FLOAT   8'h76
`define CODE_INT_OVFL    8'h79
`define CODE_BAD_HEX     8'h7a
`define CODE_FRAMING     8'haa
`define CODE_OVERRUN     8'hab
`define EVT_RESET        8'h00
`define MASK_RESET       8'h00
`endif

// *** design/status_pkg.sv ***
// Types shared by the status block
package status_pkg;
    typedef logic [7:0] fault_code_t;
    typedef logic [7:0] event_byte_t;
    typedef enum logic [3:0] {
        FLT_NONE, FLT_ILL_VALUE, FLT_ILL_MODE, FLT_LOCKED, FLT_LOST_DATA, FLT_NO_LISTEN,
        FLT_BAD_NAME, FLT_UNKNOWN, FLT_ILL_QUERY, FLT_ILL_SET, FLT_MISS_PARAM,
        FLT_BAD_FLOAT, FLT_INT_OVFL, FLT_BAD_HEX, FLT_FRAMING, FLT_OVERRUN
    } remote_fault_t;
    typedef enum logic [1:0] {
        ST_NONE, ST_ROM, ST_LINK, ST_CHAN
    } selftest_fault_t;
endpackage

// *** verification/host_query_model.sv ***
// Host-side model that pops fault codes
module host_query_model (
    input  wire logic                    clk_sys,
    input  wire status_pkg::fault_code_t faultCode,
    input  wire logic                    faultCodeValid,
    output logic                         pop_fault_code
);
    timeunit 1ns;
    timeprecision 100ps;
    import status_pkg::*;
    initial pop_fault_code = 1'b0;
    // One pop per request; code only trusted with its valid
    task automatic pop_one(output fault_code_t c);
        @(posedge clk_sys) #1 pop_fault_code = 1'b1;
        @(posedge clk_sys) #1 pop_fault_code = 1'b0;
        c = (faultCodeValid === 1'b1) ? faultCode : 8'hxx;
    endtask
endmodule // host_query_model

// *** verification/status_event_error_queue_test.sv ***
// Self-checking bench for the status and fault-code block
module status_event_error_queue_test;
    timeunit 1ns;
    timeprecision 100ps;
    import status_pkg::*;
    localparam byte unsigned CODES [16] = '{0, 10, 11, 15, 30, 32, 110, 111, 112, 113, 116, 118, 121, 122, 170, 171};
    logic clk_sys, reset_n, opsComplete, powerOnEvent, input_event_seen, cycleBusy, cycle_done, train_done;
    logic cycleInhibited, cycleAborted, pllLocked, atomicRefLocked, remoteFault, selfTestFault, calFault;
    logic readStdFlags, readInstFlags, clearStatus, writeStdMask, writeInstMask, pop_fault_code, readValid;
    logic faultCodeValid, standardSummaryFlag, instrument_summary_flag, faultLamp, dropOutput, flushBuffers;
    remote_fault_t   remoteFaultKind;
    selftest_fault_t selfTestKind;
    logic [3:0]      selfTestIndex, calIndex;
    logic [2:0]      faultCount;
    event_byte_t     maskData, readData, standardEventMask, instrument_event_mask, v;
    fault_code_t     faultCode, c;
    remote_fault_t   kinds [6];
    int              errCount, nChecks;
    status_event_error_queue #(.DEPTH(4)) dut_u (.clk_sys, .reset_n, .opsComplete, .powerOnEvent,
        .input_event_seen, .cycleBusy, .cycle_done, .train_done, .cycleInhibited, .cycleAborted, .pllLocked,
        .atomicRefLocked, .remoteFault, .remoteFaultKind, .selfTestFault, .selfTestKind, .selfTestIndex,
        .calFault, .calIndex, .readStdFlags, .readInstFlags, .clearStatus, .writeStdMask, .writeInstMask,
        .maskData, .pop_fault_code, .readData, .readValid, .faultCode, .faultCodeValid, .standardSummaryFlag,
        .instrument_summary_flag, .standardEventMask, .instrument_event_mask, .faultLamp, .faultCount,
        .dropOutput, .flushBuffers);
    host_query_model host_u (.clk_sys, .faultCode, .faultCodeValid, .pop_fault_code);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic step;
        @(posedge clk_sys) #1;
    endtask
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input bit inst, output event_byte_t r);
        {readInstFlags, readStdFlags} = inst ? 2'h2 : 2'h1;
        step;
        {readInstFlags, readStdFlags} = 2'h0;
        r = readData;
    endtask
    task automatic finishTest;
        if (errCount == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Generous bound: the whole run is under 150 cycles
    initial begin
        #20us;
        errCount++;
        finishTest;
    end
    initial begin
        {opsComplete, powerOnEvent, input_event_seen, cycleBusy, cycle_done, train_done, cycleInhibited} = '0;
        {cycleAborted, remoteFault, selfTestFault, calFault, readStdFlags, readInstFlags, clearStatus} = '0;
        {writeStdMask, writeInstMask, maskData, selfTestIndex, calIndex} = '0;
        {pllLocked, atomicRefLocked, reset_n} = 3'h6;
        remoteFaultKind = FLT_NONE;
        selfTestKind = ST_NONE;
        void'($urandom(98));
        repeat (20) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        rd(1'b0, v);
        check("std after reset", v, 8'h00);
        for (int k = 1; k < 16; k++) begin
            remoteFault = 1'b1;
            remoteFaultKind = remote_fault_t'(k);
            step;
            remoteFault = 1'b0;
            check("lamp on", faultLamp, 1'b1);
            check("drop", dropOutput, k == 4 || k == 5);
            check("flush", flushBuffers, k == 15);
            host_u.pop_one(c);
            check("remote code", c, CODES[k]);
            step;
            check("lamp off", faultLamp, 1'b0);
        end
        {calFault, calIndex} = 5'h1d;
        step;
        {calFault, selfTestFault, selfTestIndex} = 6'h1c;
        selfTestKind = ST_CHAN;
        step;
        selfTestFault = 1'b0;
        host_u.pop_one(c);
        check("cal code", c, 8'd91);
        host_u.pop_one(c);
        check("chan code", c, 8'd71);
        // Back-to-back burst into a queue of four overflows it
        remoteFault = 1'b1;
        for (int i = 0; i < 6; i++) begin
            kinds[i] = remote_fault_t'($urandom_range(15, 1));
            remoteFaultKind = kinds[i];
            step;
        end
        remoteFault = 1'b0;
        check("count", 8'(faultCount), 8'd4);
        for (int i = 0; i < 5; i++) begin
            host_u.pop_one(c);
            check("burst code", c, i < 3 ? CODES[kinds[i]] : (i == 3 ? 8'd254 : 8'd0));
        end
        clearStatus = 1'b1;
        {writeStdMask, maskData} = 9'h1ff;
        step;
        {clearStatus, writeStdMask, opsComplete, powerOnEvent} = 4'h3;
        step;
        {opsComplete, powerOnEvent} = 2'h0;
        check("std mask", standardEventMask, 8'hbd);
        check("std summary", standardSummaryFlag, 1'b1);
        rd(1'b0, v);
        check("std flags", v, 8'h81);
        step;
        rd(1'b0, v);
        check("std cleared", v, 8'h00);
        for (int b = 0; b < 6; b++) begin
            v = (b == 1) ? 8'h03 : 8'h01 << b;
            {writeInstMask, maskData} = {1'b1, 8'(v | $urandom_range(255, 0))};
            {cycleAborted, cycleInhibited, train_done, cycle_done, cycleBusy, input_event_seen} = v[5:0];
            step;
            {writeInstMask, cycleAborted, cycleInhibited, train_done, cycle_done, cycleBusy, input_event_seen} = 7'h0;
            check("inst summary", instrument_summary_flag, 1'b1);
            check("inst mask", instrument_event_mask, maskData);
            rd(1'b1, c);
            check("inst flags", c, v);
        end
        {pllLocked, atomicRefLocked} = 2'h0;
        repeat (5) step;
        rd(1'b1, v);
        check("unlock flags", v, 8'hc0);
        finishTest;
    end
endmodule // status_event_error_queue_test
